// *** logic/sacp_params.svh ***
// Constants of the serial converter control port
// ----------------------------------------------------------------------
// Summary of operation
// - each rising serial clock shifts serial_in into the address/mode register while program_enable_n is low
// - with select low, each falling serial clock presents the next result bit
// - select held low: first result bit goes out when program_enable_n_done rises, or at once if nothing was started
// - select toggled: first result bit goes out on select falling edge
// - serial output driven while select is low, released while high
// - output word carries result_bits and status, length set by mode bits
// - program_enable_n_done low during conversion, calibration, zeroing or power-down
// - select falling edge aborts a running conversion while program_enable_n is low, starts a new sequence
// - with select held low, host gives exactly word-length pulses; 13 at start
// - pulses per sequence equal the programmed word length, mode bits change it
// - shift_out_done low while shifting, high once all bits are out
// - new mode or configuration accepted only while program_enable_n is low
// - program_enable_n high: read-only sequence, input ignored, nothing starts
// - sleep_ctl high powers down; power-up takes up to 700 us
// - input_selector channel follows address bits shifted in on serial clock
// - conversion clock, not serial clock, times acquisition and conversion
// - single-ended setups use the pseudo-ground input as negative reference
// ----------------------------------------------------------------------
`ifndef SACP_PARAMS_SVH
`define SACP_PARAMS_SVH

// address and mode shift register layout
`define SACP_CFG_W 8
`define SACP_ADDR_LSB 0
`define SACP_ADDR_MSB 2
`define SACP_SE_BIT 3
`define SACP_OP_LSB 4
`define SACP_OP_MSB 7
`define SACP_OP_PROGRAM_ENABLE_N 4'h1
`define SACP_OP_CAL 4'h2
`define SACP_OP_ZERO 4'h3
`define SACP_OP_LEN 4'h4

// output word
`define SACP_RES_W 13
`define SACP_STAT_W 8
`define SACP_FRAME_W 21
`define SACP_LEN_RST 5'h0D
`define SACP_LEN_TAB_RST 20'hA90AD

// sequencing, counted in conversion clock edges
`define SACP_ACQ_CONVERSION_CLOCK 16'h000A
`define SACP_PROGRAM_ENABLE_N_CONVERSION_CLOCK 16'h002C
`define SACP_CAL_CONVERSION_CLOCK 16'h0064
`define SACP_ZERO_CONVERSION_CLOCK 16'h0014

// power-up wait in microseconds, clock rate in MHz
`define SACP_PWRUP_US 700
`define SACP_CLK_MHZ 10
`define SACP_PWRUP_CYCLES (`SACP_PWRUP_US * `SACP_CLK_MHZ)

// plain register port
`define SACP_REG_STAT 4'h0
`define SACP_REG_LEN 4'h1
`define SACP_REG_CFG 4'h2

`endif

// *** logic/sacp_pkg.sv ***
// Types of the serial converter control port
`default_nettype none
`include "sacp_params.svh"

package sacp_pkg;

  typedef enum logic [2:0] {
    OP_NONE, OP_PROGRAM_ENABLE_N, OP_CAL, OP_ZERO, OP_LEN
  } sacp_op_t;

  typedef enum logic [2:0] {
    SQ_READY, SQ_ACQ, SQ_PROGRAM_ENABLE_N, SQ_CAL, SQ_PWRDN, SQ_WAKE
  } sacp_seq_st_t;

  typedef enum logic [1:0] {
    LK_IDLE, LK_SHIFT, LK_DONE
  } sacp_link_st_t;

  typedef struct packed {
    logic sleep_ctl;
    logic program_enable_n;
    logic serial_in;
    logic sclk;
    logic select_n;
    logic conversion_clock;
  } sacp_pins_t;

  typedef struct packed {
    logic [`SACP_STAT_W-1:0] status;
    logic [`SACP_RES_W-1:0] result;
  } sacp_word_t;

  typedef struct packed {
    sacp_pins_t meta;
    sacp_pins_t stable;
  } sacp_sync_q_t;

  typedef struct packed {
    sacp_seq_st_t st;
    logic [15:0] cnt;
    logic [15:0] lim;
    logic done;
    logic cap;
  } sacp_seq_q_t;

  typedef struct packed {
    sacp_pins_t prev;
    sacp_link_st_t lk;
    logic [`SACP_CFG_W-1:0] cfg_sh;
    logic [`SACP_FRAME_W-1:0] out_sh;
    logic [4:0] bit_cnt;
    logic [4:0] word_len;
    logic [19:0] len_tab;
    logic prog;
    logic sout;
    logic sod;
    logic [2:0] chan;
    logic se;
    sacp_op_t op;
    sacp_op_t last_op;
    logic start;
    logic abort;
    logic prev_done;
    sacp_word_t res;
    logic [31:0] rdata;
  } sacp_top_q_t;

endpackage

`default_nettype wire

// *** logic/sacp_program_enable_n_seq.sv ***
// Conversion, calibration and power sequencer
`default_nettype none
`include "sacp_params.svh"

module sacp_program_enable_n_seq
  import sacp_pkg::*;
#(
  parameter int unsigned PWRUP_CYCLES = `SACP_PWRUP_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // requests from the port logic
  input wire logic conversion_clock_rise,
  input wire logic start,
  input wire sacp_op_t op,
  input wire logic abort,
  input wire logic sleep,
  // status and core strobes
  output logic program_enable_n_done,
  output logic sample_hold,
  output logic capture,
  output logic powered_down
);

  localparam logic [15:0] PWRUP_LIM = 16'(PWRUP_CYCLES - 1);

  sacp_seq_q_t q;
  sacp_seq_q_t d;

  always_comb begin
    d = q;
    d.cap = 1'b0;
    if (sleep) begin
      d.st = SQ_PWRDN;
      d.done = 1'b0;
      d.cnt = '0;
    end else if (abort && (q.st inside {SQ_ACQ, SQ_PROGRAM_ENABLE_N, SQ_CAL})) begin
      d.st = SQ_READY;
      d.done = 1'b1;
    end else begin
      unique case (q.st)
        SQ_PWRDN: begin
          d.st = SQ_WAKE;
          d.cnt = '0;
        end
        SQ_WAKE: begin
          if (q.cnt == PWRUP_LIM) begin
            d.st = SQ_READY;
            d.done = 1'b1;
          end else begin
            d.cnt = q.cnt + 16'h0001;
          end
        end
        SQ_READY: begin
          if (start) begin
            d.cnt = '0;
            unique case (op)
              OP_PROGRAM_ENABLE_N: begin
                d.st = SQ_ACQ;
                d.lim = `SACP_ACQ_CONVERSION_CLOCK;
                d.done = 1'b0;
              end
              OP_CAL: begin
                d.st = SQ_CAL;
                d.lim = `SACP_CAL_CONVERSION_CLOCK;
                d.done = 1'b0;
              end
              OP_ZERO: begin
                d.st = SQ_CAL;
                d.lim = `SACP_ZERO_CONVERSION_CLOCK;
                d.done = 1'b0;
              end
              OP_NONE, OP_LEN: begin
                d.st = SQ_READY;
              end
            endcase
          end
        end
        SQ_ACQ: begin
          if (conversion_clock_rise) begin
            if (q.cnt == q.lim - 16'h0001) begin
              d.st = SQ_PROGRAM_ENABLE_N;
              d.cnt = '0;
              d.lim = `SACP_PROGRAM_ENABLE_N_CONVERSION_CLOCK;
            end else begin
              d.cnt = q.cnt + 16'h0001;
            end
          end
        end
        SQ_PROGRAM_ENABLE_N, SQ_CAL: begin
          if (conversion_clock_rise) begin
            if (q.cnt == q.lim - 16'h0001) begin
              d.st = SQ_READY;
              d.done = 1'b1;
              d.cap = (q.st == SQ_PROGRAM_ENABLE_N);
            end else begin
              d.cnt = q.cnt + 16'h0001;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.st <= SQ_READY;
      q.done <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign program_enable_n_done = q.done;
  assign sample_hold = (q.st == SQ_ACQ);
  assign capture = q.cap;
  assign powered_down = (q.st == SQ_PWRDN) || (q.st == SQ_WAKE);

endmodule

`default_nettype wire

// *** logic/sacp_sync.sv ***
// Two-stage synchroniser for the host and conversion clock pins
`default_nettype none
`include "sacp_params.svh"

module sacp_sync
  import sacp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire sacp_pins_t pins_async,
  output sacp_pins_t pins_sync
);

  sacp_sync_q_t q;
  sacp_sync_q_t d;

  // first stage feeds only the second
  always_comb begin
    d = q;
    d.meta = pins_async;
    d.stable = q.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.meta.select_n <= 1'b1;
      q.stable.select_n <= 1'b1;
      q.meta.program_enable_n <= 1'b1;
      q.stable.program_enable_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign pins_sync = q.stable;

endmodule

`default_nettype wire

// *** logic/sacp_top.sv ***
// Serial converter control port: host link, mode decode and sequencing
`default_nettype none
`include "sacp_params.svh"

module sacp_top
  import sacp_pkg::*;
#(
  parameter int unsigned PWRUP_CYCLES = `SACP_PWRUP_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host serial pins
  input wire logic select_n,
  input wire logic sclk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  output logic program_enable_n_done,
  output logic shift_out_done,
  input wire logic program_enable_n,
  input wire logic sleep_ctl,
  // conversion clock pin
  input wire logic conversion_clock,
  // converter core
  input wire sacp_word_t core_word,
  output logic sample_hold,
  output logic capture,
  output logic powered_down,
  output logic [2:0] input_selector,
  output logic single_ended,
  output logic neg_ref_com,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------

  // opcode field compared against the table, unknown codes decode to OP_NONE and start nothing
  function automatic sacp_op_t dec_op(input logic [`SACP_CFG_W-1:0] cfg);
    logic [3:0] code;
    code = cfg[`SACP_OP_MSB:`SACP_OP_LSB];
    if (code == `SACP_OP_PROGRAM_ENABLE_N) begin
      dec_op = OP_PROGRAM_ENABLE_N;
    end else if (code == `SACP_OP_CAL) begin
      dec_op = OP_CAL;
    end else if (code == `SACP_OP_ZERO) begin
      dec_op = OP_ZERO;
    end else if (code == `SACP_OP_LEN) begin
      dec_op = OP_LEN;
    end else begin
      dec_op = OP_NONE;
    end
  endfunction

  // four five-bit word lengths packed in one table
  function automatic logic [4:0] len_pick(
    input logic [19:0] tab,
    input logic [1:0] sel
  );
    len_pick = tab[5*sel +: 5];
  endfunction

  // result first, status after it, shifted out most significant first
  function automatic logic [`SACP_FRAME_W-1:0] frame_of(
    input sacp_word_t w
  );
    frame_of = {w.result, w.status};
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------

  sacp_pins_t pins_async;
  sacp_pins_t s;

  always_comb begin
    pins_async.sleep_ctl = sleep_ctl;
    pins_async.program_enable_n = program_enable_n;
    pins_async.serial_in = serial_in;
    pins_async.sclk = sclk;
    pins_async.select_n = select_n;
    pins_async.conversion_clock = conversion_clock;
  end

  // every pin crosses two flops before the port logic looks at it
  sacp_sync u_sync (
    .clk(clk),
    .rst(rst),
    .pins_async(pins_async),
    .pins_sync(s)
  );

  // ----------------------------------------------------------------------
  // state and edge detection
  // ----------------------------------------------------------------------

  sacp_top_q_t q;
  sacp_top_q_t d;

  logic sel_fall;
  logic sel_rise;
  logic sck_rise;
  logic sck_fall;
  logic conversion_clock_rise;
  logic done_rise;
  logic seq_done;
  logic [4:0] bit_next;
  logic [`SACP_FRAME_W-1:0] frame;

  always_comb begin
    sel_fall = q.prev.select_n & ~s.select_n;
    sel_rise = ~q.prev.select_n & s.select_n;
    sck_rise = ~q.prev.sclk & s.sclk;
    sck_fall = q.prev.sclk & ~s.sclk;
    conversion_clock_rise = ~q.prev.conversion_clock & s.conversion_clock;
    done_rise = ~q.prev_done & seq_done;
    bit_next = q.bit_cnt + 5'h01;
    // a conversion ending this cycle is already the previous result
    frame = frame_of(capture ? core_word : q.res);
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------

  sacp_program_enable_n_seq #(
    .PWRUP_CYCLES(PWRUP_CYCLES)
  ) u_seq (
    .clk(clk),
    .rst(rst),
    .conversion_clock_rise(conversion_clock_rise),
    .start(q.start),
    .op(q.op),
    .abort(q.abort),
    .sleep(s.sleep_ctl),
    .program_enable_n_done(seq_done),
    .sample_hold(sample_hold),
    .capture(capture),
    .powered_down(powered_down)
  );

  // ----------------------------------------------------------------------
  // link, mode and register logic
  // ----------------------------------------------------------------------

  always_comb begin
    d = q;
    d.prev = s;
    d.prev_done = seq_done;
    d.start = 1'b0;
    d.abort = 1'b0;
    d.rdata = '0;

    // result from the core is held until the next conversion ends
    if (capture) begin
      d.res = core_word;
    end

    if (sel_rise) begin
      // an unfinished sequence is dropped, its mode bits never applied
      d.lk = LK_IDLE;
      d.sod = 1'b1;
    end else if (sel_fall) begin
      // host lowers select with the serial clock low, so no edge is lost
      d.abort = ~s.program_enable_n;
      d.out_sh = frame;
      d.sout = frame[`SACP_FRAME_W-1];
      d.bit_cnt = '0;
      d.sod = 1'b0;
      d.cfg_sh = '0;
      d.prog = ~s.program_enable_n;
      d.lk = LK_SHIFT;
    end else begin
      unique case (q.lk)
        LK_IDLE: begin
          d.lk = LK_IDLE;
        end
        LK_SHIFT: begin
          if (sck_rise && q.prog) begin
            d.cfg_sh = {q.cfg_sh[`SACP_CFG_W-2:0], s.serial_in};
          end
          if (sck_rise && !q.prog) begin
            d.cfg_sh = q.cfg_sh;
          end
          if (sck_fall) begin
            d.bit_cnt = bit_next;
            d.out_sh = {q.out_sh[`SACP_FRAME_W-2:0], 1'b0};
            d.sout = q.out_sh[`SACP_FRAME_W-2];
            if (bit_next == q.word_len) begin
              d.sod = 1'b1;
              d.lk = LK_DONE;
              if (q.prog) begin
                d.op = dec_op(q.cfg_sh);
                d.last_op = d.op;
                unique case (d.op)
                  OP_PROGRAM_ENABLE_N, OP_CAL, OP_ZERO: begin
                    d.start = 1'b1;
                    d.chan = q.cfg_sh[`SACP_ADDR_MSB:`SACP_ADDR_LSB];
                    d.se = q.cfg_sh[`SACP_SE_BIT];
                  end
                  OP_LEN: begin
                    d.word_len = len_pick(q.len_tab, q.cfg_sh[1:0]);
                  end
                  OP_NONE: begin
                    d.start = 1'b0;
                  end
                endcase
              end
            end
          end
        end
        LK_DONE: begin
          // with select held low the next sequence opens when the
          // conversion ends, or at once if nothing was started
          if (!s.select_n && (done_rise || (seq_done && !q.start))) begin
            d.out_sh = frame;
            d.sout = frame[`SACP_FRAME_W-1];
            d.bit_cnt = '0;
            d.sod = 1'b0;
            d.cfg_sh = '0;
            d.prog = ~s.program_enable_n;
            d.lk = LK_SHIFT;
          end
        end
      endcase
    end

    // register port: a write to the length table, reads one cycle later
    if (reg_wr && (reg_addr == `SACP_REG_LEN)) begin
      d.len_tab = reg_wdata[19:0];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `SACP_REG_STAT: begin
          d.rdata = {19'h00000, q.bit_cnt, q.word_len[4:1],
                     q.word_len[0], powered_down, q.sod, seq_done};
        end
        `SACP_REG_LEN: begin
          d.rdata = {12'h000, q.len_tab};
        end
        `SACP_REG_CFG: begin
          d.rdata = {21'h000000, q.lk, 1'b0, q.last_op, q.prog,
                     q.se, q.chan};
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.prev.select_n <= 1'b1;
      q.prev.program_enable_n <= 1'b1;
      q.prev_done <= 1'b1;
      q.lk <= LK_IDLE;
      q.word_len <= `SACP_LEN_RST;
      q.len_tab <= `SACP_LEN_TAB_RST;
      q.sod <= 1'b1;
      q.op <= OP_NONE;
      q.last_op <= OP_NONE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------

  assign serial_out = q.sout;
  assign serial_out_oe = ~s.select_n;
  assign program_enable_n_done = seq_done;
  assign shift_out_done = q.sod;
  assign input_selector = q.chan;
  assign single_ended = q.se;
  assign neg_ref_com = q.se;
  assign reg_rdata = q.rdata;

endmodule

`default_nettype wire

// *** tb/sacp_checker.sv ***
// Assertion checker for the serial converter control port
`default_nettype none
`include "sacp_params.svh"
module sacp_checker
  import sacp_pkg::*;
#(parameter int unsigned PWRUP_CYCLES = `SACP_PWRUP_CYCLES)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host pins
  input wire logic select_n,
  input wire logic sclk,
  input wire logic sleep_ctl,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic program_enable_n_done,
  input wire logic shift_out_done,
  // core and register port
  input wire logic capture,
  input wire logic powered_down,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  logic [3:0] since_q;
  logic [15:0] wake_q;
  logic sclk_q;
  logic sel_q;
  logic done_q;
  // raw pin edges lead the design's synchronised view by two cycles
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
    sel_q <= select_n;
    done_q <= program_enable_n_done;
    if (rst || (sclk_q && !sclk) || (sel_q && !select_n) ||
        (!done_q && program_enable_n_done)) begin
      since_q <= 4'h0;
    end else if (since_q != 4'hF) begin
      since_q <= since_q + 4'h1;
    end
    if (rst || sleep_ctl || !powered_down) begin
      wake_q <= 16'h0;
    end else begin
      wake_q <= wake_q + 16'h1;
    end
  end
  sequence s_sel_fall;
    $fell(select_n);
  endsequence
  a_oe_on: assert property (s_sel_fall |-> ##[2:4] serial_out_oe)
    else $error("output not driven after select fell");
  a_oe_off: assert property ($rose(select_n) |-> ##[2:4] !serial_out_oe)
    else $error("output still driven after select rose");
  a_sod_low: assert property (s_sel_fall |-> ##[2:4] !shift_out_done)
    else $error("shift done not low during shifting");
  a_sleep_busy: assert property ($rose(sleep_ctl) |-> ##[2:5] !program_enable_n_done)
    else $error("done high during power down");
  a_cap_done: assert property (capture |-> $rose(program_enable_n_done))
    else $error("capture without done rising");
  a_cap_pulse: assert property (capture |=> !capture)
    else $error("capture longer than one cycle");
  a_pd_busy: assert property (powered_down |-> !program_enable_n_done)
    else $error("done high while powered down");
  a_wake_bound: assert property (wake_q <= PWRUP_CYCLES + 6)
    else $error("power up wait too long");
  a_out_edge: assert property (serial_out_oe && $changed(serial_out)
    |-> since_q < 4'h6)
    else $error("serial output changed without an edge");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
endmodule
bind sacp_top sacp_checker #(.PWRUP_CYCLES(PWRUP_CYCLES)) sacp_checker_inst (
  .clk(clk), .rst(rst), .select_n(select_n), .sclk(sclk),
  .sleep_ctl(sleep_ctl), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .program_enable_n_done(program_enable_n_done),
  .shift_out_done(shift_out_done), .capture(capture),
  .powered_down(powered_down), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

// *** tb/sacp_host.sv ***
// Serial host model: select, serial clock and data toward the port
`default_nettype none
module sacp_host (
  // clock
  input wire logic clk,
  // serial pins
  output logic select_n,
  output logic sclk,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic line;
  assign line = serial_out_oe ? serial_out : 1'bz;
  initial begin
    select_n = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b0;
  end
  // serial clock is always low between frames
  task automatic sel(input logic v);
    @(posedge clk);
    select_n <= v;
    repeat (4) @(posedge clk);
  endtask
  // mode byte goes out last so it ends up in the mode register
  task automatic frame(input logic [7:0] mode, input int n,
                       output logic [20:0] got);
    logic [20:0] tx;
    tx = 21'(mode);
    got = '0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      sclk <= 1'b0;
      serial_in <= tx[i];
      repeat (4) @(posedge clk);
      got = {got[19:0], line};
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
    end
    @(posedge clk);
    sclk <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** tb/sacp_top_test.sv ***
// Self-checking bench for the serial converter control port
`default_nettype none
`include "sacp_params.svh"
module sacp_top_test
  import sacp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PW = 20;
  localparam sacp_word_t W0 = '{8'hA5, 13'h1B3C};
  localparam sacp_word_t W1 = '{8'h3C, 13'h0A71};
  logic clk, rst, select_n, sclk, serial_in, serial_out, serial_out_oe;
  logic program_enable_n_done, shift_out_done, program_enable_n, sleep_ctl;
  logic conversion_clock, capture, powered_down, single_ended, neg_ref_com;
  logic sample_hold;
  logic [2:0] input_selector;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd;
  logic [20:0] g;
  sacp_word_t core_word;
  int err_count, tests_run, cyc;
  sacp_top #(.PWRUP_CYCLES(PW)) sacp_top_inst (.clk(clk), .rst(rst),
    .select_n(select_n), .sclk(sclk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .program_enable_n_done(program_enable_n_done), .shift_out_done(shift_out_done),
    .program_enable_n(program_enable_n), .sleep_ctl(sleep_ctl),
    .conversion_clock(conversion_clock), .core_word(core_word),
    .sample_hold(sample_hold), .capture(capture), .powered_down(powered_down),
    .input_selector(input_selector), .single_ended(single_ended),
    .neg_ref_com(neg_ref_com), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  sacp_host sacp_host_inst (.clk(clk), .select_n(select_n), .sclk(sclk),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe));
  // ----------------------------------------
  // clocks, checks and closing
  // ----------------------------------------
  always #50 clk = ~clk;
  always #200 conversion_clock = ~conversion_clock;
  task automatic chk(input logic [31:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize();
    $display("tests %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  function automatic logic [20:0] expf(sacp_word_t w, int n);
    return {w.result, w.status} >> (21 - n);
  endfunction
  task automatic rw(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rr(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask
  task automatic wait_done(input int lim);
    for (int k = 0; k < lim && program_enable_n_done !== 1'b1; k++) @(posedge clk);
    chk(32'(program_enable_n_done), 32'h1, "done");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rr(4'h0, d);
    chk(32'(d[7:0]), 32'h6B, "stat");
    rw(4'hF, 32'hFFFF_FFFF);
    rr(4'hF, d);
    chk(d, 32'h0, "unmapped");
    rr(4'h1, d);
    chk(d, 32'(`SACP_LEN_TAB_RST), "len");
    $display("t_regs end");
  endtask
  task automatic t_convert();
    sacp_host_inst.sel(1'b0);
    sacp_host_inst.frame({4'h1, 1'b1, 3'h5}, 13, g);
    sacp_host_inst.sel(1'b1);
    chk(32'(program_enable_n_done), 32'h0, "busy");
    chk(32'(sample_hold), 32'h1, "acq");
    wait_done(400);
    chk(32'(input_selector), 32'h5, "chan");
    chk(32'(single_ended), 32'h1, "se");
    chk(32'(neg_ref_com), 32'h1, "com");
    sacp_host_inst.sel(1'b0);
    sacp_host_inst.frame(8'h00, 13, g);
    chk(32'(g), 32'(expf(W0, 13)), "word");
    chk(32'(shift_out_done), 32'h1, "sod");
    sacp_host_inst.sel(1'b1);
    $display("t_convert end");
  endtask
  task automatic t_held();
    @(posedge clk);
    core_word <= W1;
    sacp_host_inst.sel(1'b0);
    sacp_host_inst.frame({4'h1, 1'b0, 3'h2}, 13, g);
    // start is registered, then the sequencer lowers done
    @(posedge clk);
    chk(32'(program_enable_n_done), 32'h0, "busy");
    wait_done(400);
    sacp_host_inst.frame(8'h00, 13, g);
    chk(32'(g), 32'(expf(W1, 13)), "held");
    chk(32'(input_selector), 32'h2, "chan");
    sacp_host_inst.sel(1'b1);
    $display("t_held end");
  endtask
  // only entered with the converter idle
  task automatic t_readonly();
    @(posedge clk);
    program_enable_n <= 1'b1;
    sacp_host_inst.sel(1'b0);
    sacp_host_inst.frame({4'h1, 1'b1, 3'h7}, 13, g);
    sacp_host_inst.sel(1'b1);
    repeat (8) @(posedge clk);
    chk(32'(program_enable_n_done), 32'h1, "nostart");
    chk(32'(input_selector), 32'h2, "kept");
    chk(32'(g), 32'(expf(W1, 13)), "stored");
    program_enable_n <= 1'b0;
    $display("t_readonly end");
  endtask
  task automatic t_abort();
    sacp_host_inst.sel(1'b0);
    sacp_host_inst.frame({4'h1, 1'b0, 3'h4}, 13, g);
    sacp_host_inst.sel(1'b1);
    repeat (20) @(posedge clk);
    chk(32'(program_enable_n_done), 32'h0, "busy");
    sacp_host_inst.sel(1'b0);
    repeat (2) @(posedge clk);
    chk(32'(program_enable_n_done), 32'h1, "abort");
    // data shifted out during the aborted conversion is discarded
    sacp_host_inst.frame({4'h1, 1'b0, 3'h6}, 13, g);
    sacp_host_inst.sel(1'b1);
    chk(32'(program_enable_n_done), 32'h0, "restart");
    wait_done(400);
    chk(32'(input_selector), 32'h6, "chan");
    $display("t_abort end");
  endtask
  task automatic t_cal();
    sacp_host_inst.sel(1'b0);
    sacp_host_inst.frame({4'h2, 1'b0, 3'h6}, 13, g);
    sacp_host_inst.sel(1'b1);
    chk(32'(program_enable_n_done), 32'h0, "cal busy");
    chk(32'(sample_hold), 32'h0, "cal no acq");
    wait_done(500);
    sacp_host_inst.sel(1'b0);
    sacp_host_inst.frame({4'h3, 1'b0, 3'h6}, 13, g);
    sacp_host_inst.sel(1'b1);
    chk(32'(program_enable_n_done), 32'h0, "zero busy");
    wait_done(200);
    $display("t_cal end");
  endtask
  task automatic t_len();
    rw(4'h1, 32'h000A_C52D);
    sacp_host_inst.sel(1'b0);
    sacp_host_inst.frame(8'h41, 13, g);
    sacp_host_inst.sel(1'b1);
    rr(4'h0, d);
    chk(32'(d[7:3]), 32'h9, "wlen");
    sacp_host_inst.sel(1'b0);
    sacp_host_inst.frame(8'h00, 9, g);
    chk(32'(g), 32'(expf(W1, 9)), "short");
    chk(32'(shift_out_done), 32'h1, "sod");
    sacp_host_inst.sel(1'b1);
    $display("t_len end");
  endtask
  task automatic t_sleep();
    @(posedge clk);
    sleep_ctl <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(program_enable_n_done), 32'h0, "sleep");
    chk(32'(powered_down), 32'h1, "pd on");
    sleep_ctl <= 1'b0;
    wait_done(PW + 20);
    chk(32'(powered_down), 32'h0, "pd off");
    $display("t_sleep end");
  endtask
  initial begin
    clk = 1'b0;
    conversion_clock = 1'b0;
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    program_enable_n = 1'b0;
    sleep_ctl = 1'b0;
    core_word = W0;
    err_count = 0;
    tests_run = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_regs();
    t_convert();
    t_held();
    t_readonly();
    t_abort();
    t_cal();
    t_len();
    t_sleep();
    summarize();
  end
endmodule
`default_nettype wire
